// file: rtl/pamc_ctrl.sv
// Purpose: control-pin decoder of a 16-bit pseudo-static memory, async mode
// Assumes: host keeps its own sequencing; pins sampled on the core clock
// Notes:   storage array is outside; this block steers it and the data pins
`timescale 1ns/1ns

// Summary of operation
// - select then mode pin high: power-up
// - normal only after 200 us wait
// - default mode async page, write
// - refresh entry: enable code, pin low
// - mode pin high exits refresh directly
// - clock and address-valid ignored in async
// - wait output high-impedance in async
// - async behaviour when mode bits zero
// - decode read, write, bytes, disable
// - mode bits taken at register set
// - reserved code falls back to default
module pamc_ctrl
  import pamc_pkg::*;
(
  input  wire logic               i_core_clk,         // core clock
  input  wire logic               i_rstn,             // async reset, low
  input  wire logic               i_chip_sel_n,       // chip select pin
  input  wire logic               i_mode_reg_pin_n,   // mode-register pin
  input  wire logic               i_out_en_n,         // output enable pin
  input  wire logic               i_wr_en_n,          // write enable pin
  input  wire logic               i_low_byte_en_n,    // low byte enable
  input  wire logic               i_high_byte_en_n,   // high byte enable
  input  wire logic               i_address_valid_n,  // ignored in async
  input  wire logic               i_mem_clk,          // ignored in async
  input  wire logic [PAMC_AW-1:0] i_addr,             // address pins
  input  wire logic [PAMC_DW-1:0] i_dq,               // data pins in
  output logic      [PAMC_DW-1:0] o_dq,               // data pins out
  output logic      [PAMC_DW-1:0] o_dq_oe,            // data pin drive, per bit
  output logic                    o_wait,             // wait pin out
  output logic                    o_wait_oe,          // wait pin drive
  input  wire logic [PAMC_DW-1:0] i_arr_rdata,        // array read word
  output logic      [PAMC_AW-1:0] o_arr_addr,         // array address
  output logic      [PAMC_DW-1:0] o_arr_wdata,        // array write word
  output logic      [1:0]         o_arr_wr_be,        // array byte writes
  output logic                    o_ready,            // normal operation
  output logic                    o_partial_refresh_mode, // refresh state
  output logic      [1:0]         o_op_mode,          // effective mode select
  output logic                    o_mr_written        // register set pulse
);

  // ==========================================================
  // pin synchronisers
  localparam int unsigned NCTL = 6;  // control pins
  logic [NCTL-1:0] ctl_raw, ctl_s;   // raw and filtered controls
  logic cs_n, mode_pin_n, oe_n, we_n, lo_n, hi_n;  // filtered pins

  assign ctl_raw = {i_chip_sel_n, i_mode_reg_pin_n, i_out_en_n,
                    i_wr_en_n, i_low_byte_en_n, i_high_byte_en_n};

  // controls rest inactive (all high) through reset
  pamc_sync #(.W(NCTL), .RST_V({NCTL{1'b1}})) u_ctl_sync (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_pin      (ctl_raw),
    .o_sync     (ctl_s)
  );
  assign {cs_n, mode_pin_n, oe_n, we_n, lo_n, hi_n} = ctl_s;

  // clock and address-valid pins play no part here
  logic unused_ok;  // keeps the ignored pins visibly unused
  assign unused_ok = i_address_valid_n ^ i_mem_clk;

  // ==========================================================
  // state, counter, mode register
  pamc_state_e          st_q, st_d;      // device state
  logic [PAMC_CW-1:0]   cnt_q, cnt_d;    // wait counter
  logic                 seen_cs_q, seen_cs_d; // select rose before mode pin
  logic [PAMC_MR_W-1:0] mr_q, mr_d;      // mode register
  logic                 mrw_q, mrw_d;    // register set pulse
  logic                 regset_cmd, regset_cmd_q; // register set decode, last
  logic                 pref_code;      // refresh enable code stored

  localparam logic [PAMC_CW-1:0] PWRUP_LAST = PAMC_CW'(PAMC_PWRUP_CYC - 1);
  localparam logic [PAMC_CW-1:0] PREF_LAST  = PAMC_CW'(PAMC_PREF_CYC);

  // register set: select, mode pin, write, both bytes low; output high
  assign regset_cmd = !cs_n && !mode_pin_n && !we_n && !lo_n && !hi_n && oe_n;
  assign pref_code  = (mr_q[PAMC_PREF_HI:PAMC_PREF_LO] == PAMC_PREF_EN);

  // next state
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    seen_cs_d = seen_cs_q;
    mr_d      = mr_q;
    mrw_d     = 1'b0;
    unique case (st_q)
      // select high first, then mode pin high
      PAMC_ST_OFF: begin
        if (!cs_n) begin
          seen_cs_d = 1'b0;
        end else if (mode_pin_n && seen_cs_q) begin
          st_d  = PAMC_ST_PWRUP;
          cnt_d = '0;
        end else if (!mode_pin_n) begin
          seen_cs_d = 1'b1;
        end
      end
      // count the power-up wait; restart if pins drop
      PAMC_ST_PWRUP: begin
        if (cs_n && mode_pin_n) begin
          if (cnt_q == PWRUP_LAST) begin
            st_d = PAMC_ST_NORMAL;
            mr_d = PAMC_MR_RESET;
          end else begin
            cnt_d = cnt_q + PAMC_CW'(1);
          end
        end else begin
          cnt_d = '0;
        end
      end
      // normal: register set, and refresh entry from standby
      PAMC_ST_NORMAL: begin
        if (regset_cmd && !regset_cmd_q) begin
          mr_d  = i_addr[PAMC_MR_W-1:0];
          mrw_d = 1'b1;
        end
        if (cs_n && !mode_pin_n && pref_code) begin
          if (cnt_q == PREF_LAST) begin
            st_d  = PAMC_ST_PREF;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + PAMC_CW'(1);
          end
        end else begin
          cnt_d = '0;
        end
      end
      // refresh: mode pin high returns straight to standby
      PAMC_ST_PREF: begin
        if (mode_pin_n) begin
          st_d = PAMC_ST_NORMAL;
        end
      end
      default: begin
        st_d = PAMC_ST_OFF;
      end
    endcase
  end

  // register state
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q      <= PAMC_ST_OFF;
      cnt_q     <= '0;
      seen_cs_q <= 1'b0;
      mr_q      <= PAMC_MR_RESET;
      mrw_q     <= 1'b0;
      regset_cmd_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      seen_cs_q <= seen_cs_d;
      mr_q      <= mr_d;
      mrw_q     <= mrw_d;
      regset_cmd_q <= regset_cmd;
    end
  end

  // ==========================================================
  // effective mode: reserved code gives the default
  logic [1:0] ms;  // effective mode select
  always_comb begin
    ms = mr_q[PAMC_MS_HI:PAMC_MS_LO];
    if (ms != PAMC_MS_SBR && ms != PAMC_MS_SBRW) begin
      ms = PAMC_MS_ASYNC;
    end
  end

  // ==========================================================
  // access decode
  logic               active, async_md;        // selected, normal, async
  logic               rd, wr;                  // decoded access
  logic [1:0]         be;                      // byte lanes, 1 = on
  logic [PAMC_DW-1:0] oe_d, oe_q, dq_q, wd_q;  // pin drive and data
  logic [1:0]         wbe_d, wbe_q;            // write lanes
  logic [PAMC_AW-1:0] addr_q;                  // captured address

  assign async_md = (ms == PAMC_MS_ASYNC);
  assign active   = (st_q == PAMC_ST_NORMAL) && !cs_n && mode_pin_n && async_md;
  assign be       = {!hi_n, !lo_n};
  assign rd       = active && !oe_n && we_n;
  assign wr       = active && !we_n && oe_n;

  // per-lane drive; deselect, disable and register set release all
  always_comb begin
    oe_d  = '0;
    wbe_d = 2'b00;
    if (rd) begin
      oe_d = {{8{be[1]}}, {8{be[0]}}};
    end
    if (wr) begin
      wbe_d = be;
    end
  end

  // register pins and array strobes
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oe_q   <= '0;
      dq_q   <= '0;
      wd_q   <= '0;
      wbe_q  <= 2'b00;
      addr_q <= '0;
    end else begin
      oe_q   <= oe_d;
      dq_q   <= i_arr_rdata;
      wd_q   <= i_dq;
      wbe_q  <= wbe_d;
      addr_q <= i_addr;
    end
  end

  // ==========================================================
  // outputs
  assign o_dq        = dq_q;
  assign o_dq_oe     = oe_q;
  assign o_wait      = 1'b0;
  assign o_wait_oe   = 1'b0;
  assign o_arr_addr  = addr_q;
  assign o_arr_wdata = wd_q;
  assign o_arr_wr_be = wbe_q;
  assign o_ready     = (st_q == PAMC_ST_NORMAL);
  assign o_partial_refresh_mode = (st_q == PAMC_ST_PREF);
  assign o_op_mode   = ms;
  assign o_mr_written = mrw_q;

endmodule : pamc_ctrl

// file: rtl/pamc_pkg.sv
// Purpose: shared constants and types for the asynchronous-mode control decoder
// Assumes: 25 MHz core clock, 16-bit data, 22-bit address
// Notes:   all timing counts derive from printed times and the clock rate
package pamc_pkg;

  // ==========================================================
  // widths
  localparam int unsigned PAMC_DW = 16;  // data pins
  localparam int unsigned PAMC_AW = 22;  // address pins
  localparam int unsigned PAMC_CW = 13;  // counter width

  // ==========================================================
  // timing
  localparam int unsigned PAMC_CLK_MHZ      = 25;   // core clock rate
  localparam int unsigned PAMC_PWRUP_US     = 200;  // least power-up wait, us
  localparam int unsigned PAMC_PREF_NS      = 500;  // least refresh-entry hold, ns
  localparam int unsigned PAMC_CLK_PERIOD_NS = 40;  // clock period, ns
  // least times round up
  localparam int unsigned PAMC_PWRUP_CYC = PAMC_PWRUP_US * PAMC_CLK_MHZ;
  localparam int unsigned PAMC_PREF_CYC  =
    (PAMC_PREF_NS + PAMC_CLK_PERIOD_NS - 1) / PAMC_CLK_PERIOD_NS;

  // ==========================================================
  // mode register fields (address positions)
  localparam int unsigned PAMC_MS_HI  = 15;  // mode select high bit
  localparam int unsigned PAMC_MS_LO  = 14;  // mode select low bit
  localparam int unsigned PAMC_PREF_HI = 4;  // refresh enable high bit
  localparam int unsigned PAMC_PREF_LO = 3;  // refresh enable low bit
  localparam int unsigned PAMC_MR_W   = 18;  // stored width A17..A0

  localparam logic [1:0] PAMC_MS_ASYNC  = 2'h0;  // async page read/write
  localparam logic [1:0] PAMC_MS_SBR    = 2'h1;  // sync read, async write
  localparam logic [1:0] PAMC_MS_SBRW   = 2'h2;  // sync read/write
  localparam logic [1:0] PAMC_PREF_EN   = 2'h2;  // A4=1 A3=0
  localparam logic [17:0] PAMC_MR_RESET = 18'h0_0000;  // default register

  // ==========================================================
  // device states
  typedef enum logic [2:0] {
    PAMC_ST_OFF,     // waiting for select, then mode pin, high
    PAMC_ST_PWRUP,   // power-up wait
    PAMC_ST_NORMAL,  // normal operation
    PAMC_ST_PREF     // partial-array refresh
  } pamc_state_e;

endpackage : pamc_pkg

// file: rtl/pamc_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to i_core_clk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ns
module pamc_sync #(
  parameter int unsigned W      = 1,
  parameter logic [W-1:0] RST_V = '0
) (
  input  wire logic         i_core_clk,  // core clock
  input  wire logic         i_rstn,      // async reset, low
  input  wire logic [W-1:0] i_pin,       // raw pins
  output logic      [W-1:0] o_sync       // filtered level
);

  // ==========================================================
  // stages
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;  // chain and held output
  logic [W-1:0] out_d;                    // next output

  // per bit: take the value where stages agree
  always_comb begin
    out_d = out_q;
    for (int b = 0; b < W; b++) begin
      if (s2_q[b] == s3_q[b]) begin
        out_d[b] = s2_q[b];
      end
    end
  end

  // register the chain
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q  <= RST_V;
      s2_q  <= RST_V;
      s3_q  <= RST_V;
      out_q <= RST_V;
    end else begin
      s1_q  <= i_pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign o_sync = out_q;

endmodule : pamc_sync

// file: verif/pamc_ctrl_chk.sv
// Purpose: port checks of the async control decoder
// Assumes: one core clock, async active-low reset
// Notes:   pin filter plus output register within six edges
`timescale 1ns/1ns
module pamc_ctrl_chk
  import pamc_pkg::*;
(
  input wire logic               i_core_clk,
  input wire logic               i_rstn,
  input wire logic               i_chip_sel_n,
  input wire logic               i_mode_reg_pin_n,
  input wire logic               i_out_en_n,
  input wire logic               i_wr_en_n,
  input wire logic               i_low_byte_en_n,
  input wire logic               i_high_byte_en_n,
  input wire logic [PAMC_DW-1:0] o_dq_oe,
  input wire logic               o_wait_oe,
  input wire logic [1:0]         o_arr_wr_be,
  input wire logic               o_ready,
  input wire logic               o_partial_refresh_mode,
  input wire logic [1:0]         o_op_mode,
  input wire logic               o_mr_written
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // cycles since reset, saturating
  logic [12:0] up_q, up_d;
  always_comb up_d = (up_q == 13'h1fff) ? up_q : up_q + 13'h0001;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) up_q <= '0;
    else up_q <= up_d;
  end
  // ==========================================================
  // assertions
  property p_wait_hiz; !o_wait_oe; endproperty
  a_wait_hiz: assert property (p_wait_hiz) else $error("wait pin driven");
  property p_early; !o_ready |-> o_dq_oe == '0 && o_arr_wr_be == '0; endproperty
  a_early: assert property (p_early) else $error("access before ready");
  property p_up; $rose(o_ready) && !$past(o_partial_refresh_mode) |-> up_q >= 13'h1388; endproperty
  a_up: assert property (p_up) else $error("ready too soon");
  property p_cs_hiz; i_chip_sel_n [*6] |-> o_dq_oe == '0; endproperty
  a_cs_hiz: assert property (p_cs_hiz) else $error("data driven while deselected");
  property p_mr_hiz; (!i_chip_sel_n && !i_mode_reg_pin_n && i_out_en_n && !i_wr_en_n
    && !i_low_byte_en_n && !i_high_byte_en_n) [*6] |-> o_dq_oe == '0; endproperty
  a_mr_hiz: assert property (p_mr_hiz) else $error("data driven in register set");
  property p_mrw; o_mr_written |=> !o_mr_written; endproperty
  a_mrw: assert property (p_mrw) else $error("register set pulse too long");
  property p_rw; o_arr_wr_be != '0 |-> o_dq_oe == '0; endproperty
  a_rw: assert property (p_rw) else $error("read and write together");
  property p_pref_pin; $rose(o_partial_refresh_mode) |->
    !$past(i_mode_reg_pin_n, 8) && !$past(i_mode_reg_pin_n, 16); endproperty
  a_pref_pin: assert property (p_pref_pin) else $error("refresh without long low");
  property p_pref_exit; $fell(o_partial_refresh_mode) |-> o_ready; endproperty
  a_pref_exit: assert property (p_pref_exit) else $error("refresh exit not ready");
  property p_hold; o_ready |=> o_ready || o_partial_refresh_mode; endproperty
  a_hold: assert property (p_hold) else $error("ready lost");
  property p_mode; o_op_mode != 2'h3; endproperty
  a_mode: assert property (p_mode) else $error("reserved mode shown");
endmodule : pamc_ctrl_chk
bind pamc_ctrl pamc_ctrl_chk pamc_ctrl_chk_i (.i_core_clk, .i_rstn, .i_chip_sel_n, .i_mode_reg_pin_n,
  .i_out_en_n, .i_wr_en_n, .i_low_byte_en_n, .i_high_byte_en_n, .o_dq_oe, .o_wait_oe,
  .o_arr_wr_be, .o_ready, .o_partial_refresh_mode, .o_op_mode, .o_mr_written);

// file: verif/pamc_ctrl_test.sv
// Purpose: self-checking bench of the async control decoder
// Assumes: host model drives pins, bench drives array data
// Notes:   seeded random accesses after enumerated lane cases
`timescale 1ns/1ns
module pamc_ctrl_test;
  import pamc_pkg::*;
  // ==========================================================
  // signals
  logic               clk, rstn, cs_n, mreg_n, oe_n, we_n, lo_n, hi_n, avld_n, mclk;
  logic               wt, wt_oe, rdy, refr, mrw;
  logic [1:0]         be, opm;
  logic [PAMC_AW-1:0] addr, aa, a;
  logic [PAMC_DW-1:0] dq, rdata, dqo, dqoe, wd, d;
  logic [3:0]         sel;   // {op, high, low}
  int                 errors, comparisons, cyc, nmrw;  // nmrw: register set pulses seen
  pamc_host host_i (.i_core_clk(clk), .o_cs_n(cs_n), .o_mreg_n(mreg_n), .o_oe_n(oe_n),
    .o_we_n(we_n), .o_lo_n(lo_n), .o_hi_n(hi_n), .o_avld_n(avld_n), .o_mclk(mclk),
    .o_addr(addr), .o_dq(dq));
  pamc_ctrl pamc_ctrl_i (.i_core_clk(clk), .i_rstn(rstn), .i_chip_sel_n(cs_n),
    .i_mode_reg_pin_n(mreg_n), .i_out_en_n(oe_n), .i_wr_en_n(we_n), .i_low_byte_en_n(lo_n),
    .i_high_byte_en_n(hi_n), .i_address_valid_n(avld_n), .i_mem_clk(mclk), .i_addr(addr),
    .i_dq(dq), .o_dq(dqo), .o_dq_oe(dqoe), .o_wait(wt), .o_wait_oe(wt_oe),
    .i_arr_rdata(rdata), .o_arr_addr(aa), .o_arr_wdata(wd), .o_arr_wr_be(be),
    .o_ready(rdy), .o_partial_refresh_mode(refr), .o_op_mode(opm), .o_mr_written(mrw));
  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (mrw) nmrw++;  // count register set pulses
    cyc++;
    if (cyc == 10000) begin
      errors++;
      end_of_test();
    end
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  function automatic logic [15:0] exp_oe(input logic [3:0] s); // read lanes
    return (s[3:2] == 2'h0) ? {{8{!s[1]}}, {8{!s[0]}}} : 16'h0000;
  endfunction : exp_oe
  function automatic logic [1:0] exp_be(input logic [3:0] s); // write lanes
    return (s[3:2] == 2'h1) ? ~s[1:0] : 2'h0;
  endfunction : exp_be
  task automatic mr(input logic [21:0] v); // register set, then deselect
    int n0;
    n0 = nmrw;
    host_i.drive(6'h08, v, '0, 8);
    chk(nmrw - n0, 1);
    host_i.drive(6'h3f, '0, '0, 8);
  endtask : mr
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h2c16));
    rstn = 1'b0;
    rdata = 16'h0000;
    repeat (8) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    host_i.drive(6'h2f, '0, '0, 8); // mode pin low long enough to pass the filter
    host_i.drive(6'h3f, '0, '0, 4000); // mode pin raised after select
    chk(rdy, 0);
    host_i.drive(6'h3f, '0, '0, 1010);
    chk(rdy, 1);
    chk(opm, PAMC_MS_ASYNC);
    chk({wt_oe, wt}, 0);
    for (int k = 0; k < 32; k++) begin // all ops and lanes, then random
      sel = (k < 16) ? 4'(k) : 4'($urandom);
      a = 22'($urandom);
      d = 16'($urandom);
      rdata = 16'($urandom);
      host_i.drive({2'b01, sel[2], sel[2] ~^ sel[3], sel[0], sel[1]}, a, d, 8);
      chk(dqoe, exp_oe(sel));
      chk(be, exp_be(sel));
      if (sel[3:2] == 2'h0) chk(dqo, rdata);
      if (sel[3:2] == 2'h1) chk({aa, wd}, {a, d});
      host_i.drive(6'h3f, a, d, 8);
      chk(dqoe, 0);
    end
    mr(22'h00_4000);
    chk(opm, PAMC_MS_SBR);
    host_i.drive(6'h14, '0, '0, 8); // word read refused outside async
    chk(dqoe, 0);
    mr(22'h00_c000);
    chk(opm, PAMC_MS_ASYNC);
    host_i.drive(6'h2f, '0, '0, 30); // long low, refresh not enabled
    chk(refr, 0);
    mr(22'h00_0010);
    host_i.drive(6'h2f, '0, '0, 8); // low too short
    chk(refr, 0);
    host_i.drive(6'h3f, '0, '0, 4);
    host_i.drive(6'h2f, '0, '0, 30);
    chk({refr, rdy}, 2'h2);
    host_i.drive(6'h3f, '0, '0, 8);
    chk({refr, rdy}, 2'h1);
    end_of_test();
  end
endmodule : pamc_ctrl_test

// file: verif/pamc_host.sv
// Purpose: host controller model driving the control pins
// Assumes: pins change just after the falling clock edge
// Notes:   released data pins show the inverse of the last value
`timescale 1ns/1ns
module pamc_host
  import pamc_pkg::*;
(
  input  wire logic               i_core_clk,   // core clock
  output logic                    o_cs_n,       // chip select
  output logic                    o_mreg_n,     // mode-register pin
  output logic                    o_oe_n,       // output enable
  output logic                    o_we_n,       // write enable
  output logic                    o_lo_n,       // low byte enable
  output logic                    o_hi_n,       // high byte enable
  output logic                    o_avld_n,     // address valid, ignored
  output logic                    o_mclk,       // memory clock, ignored
  output logic      [PAMC_AW-1:0] o_addr,       // address
  output logic      [PAMC_DW-1:0] o_dq          // data toward device
);
  // ==========================================================
  // power-on: select high while mode pin still low
  initial begin
    {o_cs_n, o_mreg_n, o_oe_n, o_we_n, o_lo_n, o_hi_n} = 6'h2f;
    {o_avld_n, o_mclk, o_addr, o_dq} = '0;
  end
  // one command {cs,mode,oe,we,lo,hi}, held for n cycles
  task automatic drive(input logic [5:0] c, input logic [PAMC_AW-1:0] a,
                       input logic [PAMC_DW-1:0] d, input int n);
    @(negedge i_core_clk);
    {o_cs_n, o_mreg_n, o_oe_n, o_we_n, o_lo_n, o_hi_n} = c;
    o_addr = a;
    o_dq   = (c[5:4] == 2'b01 && !c[2]) ? d : ~o_dq;
    repeat (n) begin // ignored pins still toggle at valid levels
      @(negedge i_core_clk);
      o_avld_n = 1'($urandom);
      o_mclk   = 1'($urandom);
    end
  endtask : drive
endmodule : pamc_host
